// >>> usbl_defs.svh
// constants for the endpoint-zero and bulk loopback block
`ifndef USBL_DEFS_SVH
`define USBL_DEFS_SVH
// --------------------------------------------------------------
// master port command byte
// --------------------------------------------------------------
`define USBL_CMD_FLAG 7
`define USBL_CMD_RD 6
`define USBL_REG_STALL 6'h32
`define USBL_REG_COMMIT 6'h31
`define USBL_REG_OUTEMPTY 6'h30
`define USBL_EP6_NUM 8'h06
`define USBL_EP8_NUM 8'h08
// --------------------------------------------------------------
// port address codes and channel indices
// --------------------------------------------------------------
`define USBL_FA_CMD 3'h4
`define USBL_FA_EP0 3'h5
`define USBL_CH_EP2 3'h0
`define USBL_CH_EP4 3'h1
`define USBL_CH_EP6 3'h2
`define USBL_CH_EP8 3'h3
`define USBL_CH_EP0 3'h4
`define USBL_CHANS 5
// --------------------------------------------------------------
// buffers and events
// --------------------------------------------------------------
`define USBL_AW 4
`define USBL_CW 5
`define USBL_DEPTH 5'h10
`define USBL_IN_PKT 5'h10
`define USBL_EV_SETUP 0
`define USBL_EV_BUF 1
`define USBL_EV_FLAGS 2
// --------------------------------------------------------------
// setup packet fields
// --------------------------------------------------------------
`define USBL_REQ_CLEAR_FEATURE 8'h01
`define USBL_REQ_SET_FEATURE 8'h03
`define USBL_TYPE_STANDARD 2'h0
`define USBL_DIR_BIT 7
`endif

// >>> usbl_pkg.sv
// types for the endpoint-zero and bulk loopback block
package usbl_pkg;
    typedef struct packed {
        logic rdN;
        logic wrN;
        logic [2:0] addr;
        logic [7:0] data;
    } usbl_pins_type;
    typedef struct packed {
        logic [7:0] reqType;
        logic [7:0] request;
        logic [15:0] length;
    } usbl_setup_type;
    typedef enum logic [0:0] {CP_IDLE, CP_DATA} usbl_cmd_state_type;
    typedef enum logic [1:0] {CT_IDLE, CT_IN_WAIT, CT_OUT_WAIT} usbl_ctl_state_type;
endpackage

// >>> usbl_byte_mem.sv
// byte memory of one endpoint buffer with registered read
`timescale 1ns/1ps
`include "usbl_defs.svh"
module usbl_byte_mem import usbl_pkg::*; (
    input wire logic clock,
    input wire logic ce,
    input wire logic wrEn,
    input wire logic [`USBL_AW-1:0] wrAddr,
    input wire logic [7:0] wrData,
    input wire logic [`USBL_AW-1:0] rdAddr,
    output logic [7:0] rdData
);
    logic [7:0] store [`USBL_DEPTH];

    always_ff @(posedge clock)
    begin
        if (ce)
        begin
            if (wrEn)
                store[wrAddr] <= wrData;
            rdData <= store[rdAddr];
        end
    end
endmodule // usbl_byte_mem

// >>> usbl_core.sv
// endpoint-zero request handling and bulk endpoint buffers with master byte port
// Function
// [R1] standard requests are answered inside, except endpoint Set/Clear Feature; the code forwards Set/Clear Feature of any recipient
// [R2] Set or Clear Feature raises the setup event toward the master
// [R3] master sets or clears the addressed endpoint stall on those requests
// [R4] master stalls a control request by writing non-zero to register 0x32
// [R5] master acknowledges vendor requests 0xAA and 0xAB
// [R6] master stalls every control request it does not recognise
// [R7] a forwarded setup with non-zero length raises the buffer event
// [R8] for IN transfers the buffer event waits until the EP0 buffer is free
// [R9] for OUT transfers the buffer event follows a received EP0 packet
// [R10] data arriving in EP2 or EP4 raises the flag event
// [R11] EP2 and EP4 empty state is readable in a status register
// [R12] master loops EP2 into EP6 and EP4 into EP8
// [R13] master moves loop data byte by byte until the source is empty
// [R14] master writes the commit register on vendor requests 0xB6 or 0xB8
// [R15] commit write hands held EP6 or EP8 data to USB as short packet
// [R16] register read: command byte, interrupt goes low, then data is read
// [R17] master clears its buffer-ready indication before the next buffer event
`timescale 1ns/1ps
`include "usbl_defs.svh"
module usbl_core import usbl_pkg::*; (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire usbl_pins_type masterPins,
    output logic [7:0] masterDataOut,
    output logic masterDataOe,
    output logic readyPin,
    output logic masterIntN,
    input wire logic setupValid,
    input wire usbl_setup_type setupPkt,
    input wire logic usbOutValid,
    input wire logic [1:0] usbOutEp,
    input wire logic [7:0] usbOutData,
    input wire logic usbOutLast,
    output logic [2:0] usbOutReady,
    input wire logic usbInPop,
    input wire logic [1:0] usbInEp,
    output logic [7:0] usbInData,
    output logic [2:0] usbInAvail,
    output logic stdAnswer,
    output logic ctrlStall
);
    // --------------------------------------------------------------
    // pin synchronisers and strobe edges
    // --------------------------------------------------------------
    usbl_pins_type pinMeta, pinSync, pinPrev;
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pinMeta <= '{rdN: 1'b1, wrN: 1'b1, addr: 3'h0, data: 8'h00};
            pinSync <= '{rdN: 1'b1, wrN: 1'b1, addr: 3'h0, data: 8'h00};
            pinPrev <= '{rdN: 1'b1, wrN: 1'b1, addr: 3'h0, data: 8'h00};
        end
        else if (ce)
        begin
            pinMeta <= masterPins;
            pinSync <= pinMeta;
            pinPrev <= pinSync;
        end
    end
    wire rdFall = pinPrev.rdN & ~pinSync.rdN;
    wire rdRise = ~pinPrev.rdN & pinSync.rdN;
    wire wrRise = ~pinPrev.wrN & pinSync.wrN;
    wire isCmdAddr = pinSync.addr == `USBL_FA_CMD;
    wire isFifoAddr = (pinSync.addr < `USBL_FA_CMD) | (pinSync.addr == `USBL_FA_EP0);
    wire [2:0] mstCh = (pinSync.addr == `USBL_FA_EP0) ? `USBL_CH_EP0 : pinSync.addr;
    wire [7:0] mstByte = pinSync.data;

    // --------------------------------------------------------------
    // endpoint buffers
    // --------------------------------------------------------------
    wire [2:0] usbOutCh = (usbOutEp == 2'h2) ? `USBL_CH_EP0 : {1'b0, usbOutEp};
    wire [2:0] usbInCh = (usbInEp == 2'h2) ? `USBL_CH_EP0 : `USBL_CH_EP6 + {2'h0, usbInEp[0]};
    wire mstPush = wrRise & isFifoAddr;
    wire mstPop = rdRise & isFifoAddr;
    logic [`USBL_CW-1:0] cnt [`USBL_CHANS];
    logic [7:0] head [`USBL_CHANS];
    logic [`USBL_CHANS-1:0] pushOk, popOk, usbPushCh;
    for (genvar i = 0; i < `USBL_CHANS; i++)
    begin : g_ch
        logic [`USBL_AW-1:0] wrPtr, rdPtr;
        logic [`USBL_CW-1:0] count;
        wire usbHere = usbOutValid & (usbOutCh == 3'(i));
        wire push = usbHere | (mstPush & (mstCh == 3'(i)));
        wire pop = (usbInPop & (usbInCh == 3'(i))) | (mstPop & (mstCh == 3'(i)));
        assign usbPushCh[i] = usbHere & (count != `USBL_DEPTH);
        assign pushOk[i] = push & (count != `USBL_DEPTH);
        assign popOk[i] = pop & (count != `USBL_CW'(0));
        assign cnt[i] = count;
        always_ff @(posedge clock)
        begin
            if (rst)
            begin
                wrPtr <= '0;
                rdPtr <= '0;
                count <= '0;
            end
            else if (ce)
            begin
                wrPtr <= wrPtr + `USBL_AW'(pushOk[i]);
                rdPtr <= rdPtr + `USBL_AW'(popOk[i]);
                count <= count + `USBL_CW'(pushOk[i]) - `USBL_CW'(popOk[i]);
            end
        end
        // usb side wins when both parties write the EP0 buffer in one cycle
        usbl_byte_mem u_mem (
            .clock(clock),
            .ce(ce),
            .wrEn(pushOk[i]),
            .wrAddr(wrPtr),
            .wrData(usbHere ? usbOutData : mstByte),
            .rdAddr(rdPtr),
            .rdData(head[i])
        );
    end

    // --------------------------------------------------------------
    // command port decode
    // --------------------------------------------------------------
    usbl_cmd_state_type cpState;
    logic [5:0] regAddr;
    logic readPend, readPendShown;
    logic [7:0] readValue;
    logic [2:0] events, shownEv;
    logic [1:0] committed;
    wire cmdWr = wrRise & isCmdAddr;
    wire isCommand = mstByte[`USBL_CMD_FLAG];
    wire cmdRead = cmdWr & isCommand & mstByte[`USBL_CMD_RD];
    wire cmdWrReg = cmdWr & isCommand & ~mstByte[`USBL_CMD_RD];
    wire dataWr = cmdWr & ~isCommand & (cpState == CP_DATA);
    wire regStall = dataWr & (regAddr == `USBL_REG_STALL) & (mstByte != 8'h00);
    wire regCommit = dataWr & (regAddr == `USBL_REG_COMMIT);
    wire commit6 = regCommit & (mstByte == `USBL_EP6_NUM);
    wire commit8 = regCommit & (mstByte == `USBL_EP8_NUM);
    wire [7:0] outEmpty = {6'h00, cnt[`USBL_CH_EP4] == '0, cnt[`USBL_CH_EP2] == '0};
    wire [7:0] readMux = (mstByte[5:0] == `USBL_REG_OUTEMPTY) ? outEmpty : 8'h00; // R11
    wire readDone = rdRise & isCmdAddr & readPendShown;
    wire [2:0] evClr = (rdRise & isCmdAddr & ~readPendShown) ? shownEv : 3'h0;

    // --------------------------------------------------------------
    // setup routing and control transfer tracking
    // --------------------------------------------------------------
    usbl_ctl_state_type ctState, next_ctState;
    wire isStandard = setupPkt.reqType[6:5] == `USBL_TYPE_STANDARD;
    wire isFeature = (setupPkt.request == `USBL_REQ_SET_FEATURE)
                   | (setupPkt.request == `USBL_REQ_CLEAR_FEATURE);
    wire toMaster = ~isStandard | isFeature; // R1 R2
    wire setupFwd = setupValid & toMaster;
    wire hasData = setupPkt.length != 16'h0000;
    wire ep0Free = cnt[`USBL_CH_EP0] == '0;
    wire ep0Packet = usbPushCh[`USBL_CH_EP0] & usbOutLast;
    wire bufSet = ((ctState == CT_IN_WAIT) & ep0Free)
                | ((ctState == CT_OUT_WAIT) & ep0Packet); // R8 R9
    wire flagsSet = usbPushCh[`USBL_CH_EP2] | usbPushCh[`USBL_CH_EP4]; // R10
    wire [2:0] evSet = {flagsSet, bufSet, setupFwd};
    wire [2:0] next_events = (events & ~evClr) | evSet; // set wins over clear
    always_comb
    begin
        next_ctState = ctState;
        case (ctState)
            CT_IDLE:
                if (setupFwd & hasData) // R7
                    next_ctState = setupPkt.reqType[`USBL_DIR_BIT] ? CT_IN_WAIT : CT_OUT_WAIT;
            CT_IN_WAIT:
                if (ep0Free)
                    next_ctState = CT_IDLE;
            CT_OUT_WAIT:
                if (ep0Packet)
                    next_ctState = CT_IDLE;
            default:
                next_ctState = CT_IDLE;
        endcase
        if (setupValid & ~(setupFwd & hasData))
            next_ctState = CT_IDLE;
    end

    // --------------------------------------------------------------
    // state registers
    // --------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cpState <= CP_IDLE;
            regAddr <= 6'h00;
            readPend <= 1'b0;
            readPendShown <= 1'b0;
            readValue <= 8'h00;
            events <= 3'h0;
            shownEv <= 3'h0;
            ctState <= CT_IDLE;
            committed <= 2'h0;
            ctrlStall <= 1'b0;
            stdAnswer <= 1'b0;
        end
        else if (ce)
        begin
            if (cmdWrReg)
                cpState <= CP_DATA;
            else if (dataWr | cmdRead)
                cpState <= CP_IDLE;
            if (cmdWrReg | cmdRead)
                regAddr <= mstByte[5:0];
            if (cmdRead)
                readValue <= readMux; // R16
            readPend <= cmdRead | (readPend & ~readDone); // R16
            if (rdFall)
            begin
                readPendShown <= readPend;
                shownEv <= events;
            end
            events <= next_events; // R2 R10
            ctState <= next_ctState;
            committed[0] <= commit6 | (committed[0] & (cnt[`USBL_CH_EP6] != '0)); // R15
            committed[1] <= commit8 | (committed[1] & (cnt[`USBL_CH_EP8] != '0)); // R15
            ctrlStall <= regStall | (ctrlStall & ~setupValid);
            stdAnswer <= setupValid & ~toMaster; // R1
        end
    end

    // --------------------------------------------------------------
    // registered outputs
    // --------------------------------------------------------------
    wire [7:0] rdMux = isCmdAddr ? (readPend ? readValue : {5'h00, events}) : head[mstCh];
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            masterDataOut <= 8'h00;
            masterDataOe <= 1'b0;
            readyPin <= 1'b0;
            masterIntN <= 1'b1;
            usbOutReady <= 3'h0;
            usbInData <= 8'h00;
            usbInAvail <= 3'h0;
        end
        else if (ce)
        begin
            if (rdFall)
                masterDataOut <= rdMux;
            masterDataOe <= rdFall | (masterDataOe & ~rdRise);
            readyPin <= ~readPend; // R16
            masterIntN <= ~((|events) | readPend); // R16
            usbOutReady <= {cnt[`USBL_CH_EP0] < `USBL_DEPTH, cnt[`USBL_CH_EP4] < `USBL_DEPTH,
                            cnt[`USBL_CH_EP2] < `USBL_DEPTH};
            usbInData <= head[usbInCh];
            usbInAvail[0] <= committed[0] | (cnt[`USBL_CH_EP6] >= `USBL_IN_PKT); // R15
            usbInAvail[1] <= committed[1] | (cnt[`USBL_CH_EP8] >= `USBL_IN_PKT); // R15
            usbInAvail[2] <= ~ep0Free;
        end
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    property p_std_answer;
        @(posedge clock) disable iff (rst)
            ce & setupValid & ~toMaster |=> stdAnswer & ~$rose(events[`USBL_EV_SETUP]);
    endproperty
    a_std_answer: assert property (p_std_answer) else $error("standard request not answered"); // R1
    property p_setup_event;
        @(posedge clock) disable iff (rst) ce & setupFwd |=> events[`USBL_EV_SETUP];
    endproperty
    a_setup_event: assert property (p_setup_event) else $error("setup event missing"); // R2
    property p_len_zero;
        @(posedge clock) disable iff (rst) ce & setupFwd & ~hasData |=> ctState == CT_IDLE;
    endproperty
    a_len_zero: assert property (p_len_zero) else $error("zero length started data stage"); // R7
    property p_in_free;
        @(posedge clock) disable iff (rst)
            ce & (ctState == CT_IN_WAIT) & ~ep0Free & ~events[`USBL_EV_BUF]
            |=> ~events[`USBL_EV_BUF];
    endproperty
    a_in_free: assert property (p_in_free) else $error("buffer event while buffer busy"); // R8
    property p_out_pkt;
        @(posedge clock) disable iff (rst)
            ce & (ctState == CT_OUT_WAIT) & ep0Packet |=> events[`USBL_EV_BUF] & (ctState == CT_IDLE);
    endproperty
    a_out_pkt: assert property (p_out_pkt) else $error("out packet gave no buffer event"); // R9
    property p_flags;
        @(posedge clock) disable iff (rst) ce & flagsSet |=> events[`USBL_EV_FLAGS];
    endproperty
    a_flags: assert property (p_flags) else $error("flag event missing"); // R10
    property p_empty_reg;
        @(posedge clock) disable iff (rst)
            ce & cmdRead & (mstByte[5:0] == `USBL_REG_OUTEMPTY)
            |=> readValue == {6'h00, $past(cnt[`USBL_CH_EP4] == '0), $past(cnt[`USBL_CH_EP2] == '0)};
    endproperty
    a_empty_reg: assert property (p_empty_reg) else $error("empty status wrong"); // R11
    property p_commit;
        @(posedge clock) disable iff (rst) ce & commit6 |=> committed[0] ##1 ~ce | usbInAvail[0];
    endproperty
    a_commit: assert property (p_commit) else $error("commit did not release data"); // R15
    property p_read_int;
        @(posedge clock) disable iff (rst) ce & cmdRead |=> readPend ##1 ~ce | ~masterIntN;
    endproperty
    a_read_int: assert property (p_read_int) else $error("read did not pull interrupt low"); // R16
endmodule // usbl_core

// >>> usbl_master_model.sv
// master processor model driving the asynchronous byte port
`timescale 1ns/1ps
`include "usbl_defs.svh"
module usbl_master_model import usbl_pkg::*; (
    input wire logic clock,
    output usbl_pins_type pins,
    input wire logic [7:0] masterDataOut,
    input wire logic masterDataOe,
    input wire logic readyPin,
    input wire logic masterIntN
);
    logic [7:0] lastData;
    initial
    begin
        pins = '{rdN: 1'b1, wrN: 1'b1, addr: 3'h0, data: 8'hFF};
        lastData = 8'h00;
    end
    // strobes stay 7 cycles low and 7 high, address and data held through the high phase
    task automatic strobe(input logic [2:0] a, input logic [7:0] d, input logic rd,
        output logic [7:0] q);
        @(negedge clock);
        pins.addr = a;
        pins.data = rd ? ~lastData : d;
        pins.rdN = ~rd;
        pins.wrN = rd;
        repeat (7) @(negedge clock);
        // undriven bus shows the inverse of its last value
        q = masterDataOe ? masterDataOut : ~lastData;
        lastData = rd ? q : d;
        pins.rdN = 1'b1;
        pins.wrN = 1'b1;
        repeat (7) @(negedge clock);
        pins.data = ~lastData;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        strobe(a, d, 1'b0, q);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] q);
        strobe(a, 8'h00, 1'b1, q);
    endtask
    task automatic regWrite(input logic [5:0] r, input logic [7:0] v);
        wr(`USBL_FA_CMD, {2'b10, r});
        wr(`USBL_FA_CMD, v);
    endtask
    task automatic regRead(input logic [5:0] r, output logic [7:0] v);
        int n;
        for (n = 0; n < 200 && readyPin !== 1'b1; n++) @(negedge clock);
        wr(`USBL_FA_CMD, {2'b11, r});
        for (n = 0; n < 200 && masterIntN !== 1'b0; n++) @(negedge clock);
        rd(`USBL_FA_CMD, v);
    endtask
endmodule // usbl_master_model

// >>> tb_usb_ep0_and_bulk_loopback.sv
// self-checking testbench for the endpoint-zero and bulk loopback block
`timescale 1ns/1ps
`include "usbl_defs.svh"
module tb_usb_ep0_and_bulk_loopback
    import usbl_pkg::*;
;
    logic clock, rst, setupValid, usbOutValid, usbOutLast, usbInPop;
    logic masterDataOe, readyPin, masterIntN, stdAnswer, ctrlStall;
    logic [7:0] masterDataOut, usbOutData, usbInData, q;
    logic [1:0] usbOutEp, usbInEp;
    logic [2:0] usbOutReady, usbInAvail;
    usbl_pins_type pins;
    usbl_setup_type setupPkt;
    int bad_count, checked, cycles;
    usbl_core dut_u (.clock(clock), .rst(rst), .ce(1'b1), .masterPins(pins),
        .masterDataOut(masterDataOut), .masterDataOe(masterDataOe), .readyPin(readyPin),
        .masterIntN(masterIntN), .setupValid(setupValid), .setupPkt(setupPkt),
        .usbOutValid(usbOutValid), .usbOutEp(usbOutEp), .usbOutData(usbOutData),
        .usbOutLast(usbOutLast), .usbOutReady(usbOutReady), .usbInPop(usbInPop),
        .usbInEp(usbInEp), .usbInData(usbInData), .usbInAvail(usbInAvail),
        .stdAnswer(stdAnswer), .ctrlStall(ctrlStall));
    usbl_master_model mst_u (.clock(clock), .pins(pins), .masterDataOut(masterDataOut),
        .masterDataOe(masterDataOe), .readyPin(readyPin), .masterIntN(masterIntN));
    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            bad_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    // one setup packet, then count the cycles of internal answer
    task automatic setup(input logic [7:0] t, input logic [7:0] r, input logic [15:0] len,
        input logic [7:0] ans);
        int n;
        @(negedge clock);
        setupPkt = '{reqType: t, request: r, length: len};
        setupValid = 1'b1;
        @(negedge clock);
        setupValid = 1'b0;
        n = 0;
        repeat (4)
        begin
            n += (stdAnswer === 1'b1);
            @(negedge clock);
        end
        chk(8'(n), ans, "answer pulses");
    endtask
    task automatic push(input logic [1:0] ep, input logic [7:0] d, input logic last);
        @(negedge clock);
        {usbOutEp, usbOutData, usbOutLast, usbOutValid} = {ep, d, last, 1'b1};
        @(negedge clock);
        {usbOutLast, usbOutValid} = 2'b00;
        repeat (2) @(negedge clock);
    endtask
    task automatic pop(input logic [1:0] ep, input logic [7:0] exp);
        usbInEp = ep;
        repeat (3) @(negedge clock);
        chk(usbInData, exp, "in head");
        usbInPop = 1'b1;
        @(negedge clock);
        usbInPop = 1'b0;
    endtask
    task automatic evt(input logic [7:0] exp);
        mst_u.rd(`USBL_FA_CMD, q);
        chk(q, exp, "event byte");
    endtask
    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic t_requests();
        setup(8'h80, 8'h06, 16'h0000, 8'h01);
        chk({7'h0, masterIntN}, 8'h01, "std no event");
        for (int i = 0; i < 2; i++)
        begin
            setup(8'h02, i ? `USBL_REQ_CLEAR_FEATURE : `USBL_REQ_SET_FEATURE, 0, 8'h00);
            chk({6'h0, masterIntN, ctrlStall}, 8'h00, "feature event");
            evt(8'h01);
            mst_u.regWrite(`USBL_REG_STALL, 8'h01);
            chk({7'h0, ctrlStall}, 8'h01, "feature stall");
        end
        setup(8'h40, 8'h55, 16'h0000, 8'h00);
        evt(8'h01);
        mst_u.regWrite(`USBL_REG_STALL, 8'h00);
        chk({7'h0, ctrlStall}, 8'h00, "zero stall write");
        mst_u.regWrite(`USBL_REG_STALL, 8'h7F);
        chk({7'h0, ctrlStall}, 8'h01, "stall");
        $display("requests done");
    endtask
    task automatic t_ep0();
        setup(8'hC0, 8'hAA, 16'h0008, 8'h00);
        chk({7'h0, ctrlStall}, 8'h00, "stall cleared");
        evt(8'h03);
        mst_u.wr(`USBL_FA_EP0, 8'h5A);
        setup(8'hC0, 8'hAB, 16'h0008, 8'h00);
        evt(8'h01);
        pop(2'h2, 8'h5A);
        repeat (3) @(negedge clock);
        chk({7'h0, usbInAvail[2]}, 8'h00, "ep0 drained");
        evt(8'h02);
        setup(8'h40, 8'hAB, 16'h0002, 8'h00);
        evt(8'h01);
        push(2'h2, 8'h11, 1'b0);
        evt(8'h00);
        push(2'h2, 8'h22, 1'b1);
        evt(8'h02);
        chk({7'h0, usbInAvail[2]}, 8'h01, "ep0 out data held");
        $display("ep0 done");
    endtask
    task automatic t_loop();
        logic [7:0] d;
        int n;
        for (int ch = 0; ch < 2; ch++)
        begin
            for (int k = 0; k < 3; k++) push(2'(ch), 8'(8'hA0 + ch * 16 + k), 1'b0);
            evt(8'h04);
            chk({7'h0, readyPin}, 8'h01, "ready idle");
            mst_u.wr(`USBL_FA_CMD, {2'b11, `USBL_REG_OUTEMPTY});
            chk({6'h0, readyPin, masterIntN}, 8'h00, "read pending");
            mst_u.rd(`USBL_FA_CMD, q);
            chk(q, ch ? 8'h01 : 8'h02, "empty status");
            for (n = 0; n < 6; n++)
            begin
                mst_u.regRead(`USBL_REG_OUTEMPTY, q);
                if (q[ch] === 1'b1)
                    break;
                mst_u.rd(3'(ch), d);
                mst_u.wr(3'(ch + 2), d);
            end
            chk(8'(n), 8'h03, "bytes moved");
            chk({7'h0, usbInAvail[ch]}, 8'h00, "short not sent");
            mst_u.regWrite(`USBL_REG_COMMIT, ch ? `USBL_EP8_NUM : `USBL_EP6_NUM);
            chk({7'h0, usbInAvail[ch]}, 8'h01, "committed");
            for (int k = 0; k < 3; k++) pop(2'(ch), 8'(8'hA0 + ch * 16 + k));
        end
        $display("loopback done");
    endtask
    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial
    begin
        {rst, setupValid, usbOutValid, usbOutLast, usbInPop} = 5'b10000;
        {usbOutEp, usbInEp, usbOutData} = 12'h000;
        setupPkt = '0;
        bad_count = 0;
        checked = 0;
        cycles = 0;
        repeat (10) @(negedge clock);
        rst = 1'b0;
        repeat (3) @(negedge clock);
        chk({3'h0, masterIntN, ctrlStall, usbOutReady}, 8'h17, "reset state");
        t_requests();
        t_ep0();
        t_loop();
        end_sim();
    end
endmodule // tb_usb_ep0_and_bulk_loopback
